/* File: core/iost_pkg.sv */
package iost_pkg;
  // segment descriptor fields (bit 0 is the msb in the big-endian numbering)
  localparam int SD_TYPE_POS   = 31;
  localparam int SD_SKEY_POS   = 30;
  localparam int SD_UKEY_POS   = 29;
  localparam int SD_BUS_UNIT_IDENTIFIER_MSB   = 28;
  localparam int SD_BUS_UNIT_IDENTIFIER_LSB   = 20;
  localparam int SD_HIGH_MSB   = 3;
  localparam int SD_HIGH_LSB   = 0;
  localparam logic [8:0] BUS_UNIT_IDENTIFIER_MEM_FORCED = 9'h07F;
  localparam logic [2:0] ATTR_IO   = 3'h2;
  localparam logic [2:0] ATTR_MEMF = 3'h3;
  // cause bit five counted from the msb, the same numbering as the descriptor
  localparam int FAULT_CAUSE_BIT = 26;
  // register map on the plain port
  localparam logic [3:0] ADDR_SEGDESC = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_FAULT   = 4'h8;
  localparam logic [31:0] SEGDESC_RST = 32'h00000000;

  typedef enum logic [1:0] {OP_LOAD, OP_STORE, OP_FETCH} iost_kind_t;
  typedef enum logic [2:0] {IX_NORMAL, IX_RESERVE, IX_EXTCTL, IX_CACHEOP} iost_ixclass_t;

  typedef struct packed {
    logic [31:0]   logAddr;
    iost_kind_t    kind;
    iost_ixclass_t ixClass;
    logic          privState;
    logic          dataXlateEn;
  } iost_req_t;

  typedef struct packed {
    logic        valid;
    logic        addrOnly;
    logic        isSecond;
    logic [31:0] addr;
    logic [2:0]  attr;
  } iost_bus_t;
endpackage

/* File: core/iost_unit.sv */
`timescale 1ns/1ns
// How it works
// - type bit one selects io translation
// - descriptor fields decoded at documented bit positions
// - block translation hit ignored for io
// - no page table lookup for io
// - two address only packets to controller
// - key chosen by privilege state bit
// - first packet carries descriptor bits three-31
// - second packet high bits plus address low
// - io attributes forced to 010
// - each bus transaction translated on its own
// - identifier 07F makes memory forced access
// - forced access skips protection, direct address
// - forced access attributes are 011
// - one descriptor maps whole 256 MB region
// - reserve/compare loads fault, cause bit five
// - external control ops flagged undefined
// - cache block ops become no-ops
module iost_unit
  import iost_pkg::*;
(
  input  wire logic        core_clk,    // 250 MHz clock
  input  wire logic        rst_n,       // sync reset, active low
  input  wire logic        reqValid,    // one access per pulse
  input  iost_req_t        req,         // access description
  input  wire logic        blockHit,    // block translation hit
  output logic             reqReady,    // may take a request
  output logic             pageWalk,    // page table search request
  output iost_bus_t        busOut,      // bus transaction
  output logic             dataFault,   // data access exception pulse
  output logic             undefResult, // result undefined pulse
  output logic             noOp,        // access dropped pulse
  input  wire logic [3:0]  regAddr,     // register address
  input  wire logic [31:0] regWdata,    // write data
  input  wire logic        regWr,       // write strobe
  input  wire logic        regRd,       // read strobe
  output logic [31:0]      regRdata     // read data, one cycle later
);

  typedef enum {S_IDLE, S_SECOND} iost_state_t;

  ////////////////////////////////////////////////////////////////////
  // descriptor decode, shared by the packet builders
  function automatic logic key_for(input logic [31:0] desc, input logic userMode);
    return userMode ? desc[SD_UKEY_POS] : desc[SD_SKEY_POS];
  endfunction

  // a 256 MB window: four descriptor bits over the 28 low address bits
  function automatic logic [31:0] direct_for(input logic [31:0] desc, input logic [31:0] la);
    return {desc[SD_HIGH_MSB:SD_HIGH_LSB], la[27:0]};
  endfunction

  function automatic logic [31:0] first_for(input logic [31:0] desc, input logic userMode);
    return {key_for(desc, userMode), 2'b00, desc[SD_BUS_UNIT_IDENTIFIER_MSB:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  logic [31:0] segDesc_q, segDesc_d;
  logic [31:0] fault_q, fault_d;
  logic [31:0] rdata_q, rdata_d;
  iost_state_t state_q, state_d;
  iost_bus_t   bus_q, bus_d;
  logic [31:0] second_q, second_d;
  logic        pw_q, pw_d;
  logic        flt_q, flt_d;
  logic        und_q, und_d;
  logic        nop_q, nop_d;
  logic        rdy_q, rdy_d;
  logic [31:0] ioCnt_q, ioCnt_d;

  wire logic       isIo    = segDesc_q[SD_TYPE_POS];
  wire logic [8:0] bus_unit_identifier    = segDesc_q[SD_BUS_UNIT_IDENTIFIER_MSB:SD_BUS_UNIT_IDENTIFIER_LSB];
  wire logic       memForc = isIo && (bus_unit_identifier == BUS_UNIT_IDENTIFIER_MEM_FORCED);
  wire logic       keyBit  = key_for(segDesc_q, req.privState);
  wire logic       accept  = reqValid && (state_q == S_IDLE);
  wire logic [31:0] directAddr = direct_for(segDesc_q, req.logAddr);

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d  = state_q;
    bus_d    = '0;
    second_d = second_q;
    pw_d     = 1'b0;
    flt_d    = 1'b0;
    und_d    = 1'b0;
    nop_d    = 1'b0;
    // software write first, so a fault in the same cycle still sets its bit
    fault_d  = (regWr && regAddr == ADDR_FAULT) ? regWdata : fault_q;
    ioCnt_d  = ioCnt_q;
    unique case (state_q)
      S_IDLE: begin
        if (reqValid) begin
          if (!isIo) begin
            // non-io path: page walk unless block hit covers it
            if (req.ixClass == IX_EXTCTL && !req.dataXlateEn) begin
              // translation is off, so there is nothing to walk
              und_d = 1'b1;
            end else begin
              pw_d = !blockHit;
            end
          end else if (req.ixClass == IX_RESERVE) begin
            flt_d = 1'b1;
            fault_d[FAULT_CAUSE_BIT] = 1'b1;
          end else if (req.ixClass == IX_EXTCTL) begin
            und_d = 1'b1;
          end else if (req.ixClass == IX_CACHEOP) begin
            nop_d = 1'b1;
          end else if (memForc) begin
            // protection bypassed; key not consulted
            bus_d = '{valid: 1'b1, addrOnly: 1'b0, isSecond: 1'b0, addr: directAddr, attr: ATTR_MEMF};
          end else begin
            // blockHit ignored, no walk: controller checks key
            bus_d = '{valid: 1'b1, addrOnly: 1'b1, isSecond: 1'b0,
                      addr: first_for(segDesc_q, req.privState), attr: ATTR_IO};
            second_d = directAddr;
            state_d  = S_SECOND;
            ioCnt_d  = ioCnt_q + 32'h00000001;
          end
        end
      end
      S_SECOND: begin
        bus_d   = '{valid: 1'b1, addrOnly: 1'b1, isSecond: 1'b1, addr: second_q, attr: ATTR_IO};
        state_d = S_IDLE;
      end
    endcase
  end

  always_comb begin
    segDesc_d = segDesc_q;
    if (regWr && regAddr == ADDR_SEGDESC) begin
      segDesc_d = regWdata;
    end
    rdata_d = 32'h00000000;
    if (regRd) begin
      unique case (regAddr)
        ADDR_SEGDESC: rdata_d = segDesc_q;
        ADDR_STATUS:  rdata_d = ioCnt_q;
        ADDR_FAULT:   rdata_d = fault_q;
        default:      rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fault_q   <= 32'h00000000;
      state_q   <= S_IDLE;
      bus_q     <= '0;
      second_q  <= 32'h00000000;
      pw_q      <= 1'b0;
      flt_q     <= 1'b0;
      und_q     <= 1'b0;
      nop_q     <= 1'b0;
      ioCnt_q   <= 32'h00000000;
    end else begin
      fault_q   <= fault_d;
      state_q   <= state_d;
      bus_q     <= bus_d;
      second_q  <= second_d;
      pw_q      <= pw_d;
      flt_q     <= flt_d;
      und_q     <= und_d;
      nop_q     <= nop_d;
      ioCnt_q   <= ioCnt_d;
    end
  end

  // register group: descriptor and the read port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      segDesc_q <= SEGDESC_RST;
      rdata_q   <= 32'h00000000;
    end else begin
      segDesc_q <= segDesc_d;
      rdata_q   <= rdata_d;
    end
  end

  // ready is registered so the second packet never meets a new access
  always_comb begin
    rdy_d = (state_d == S_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdy_q <= 1'b1;
    end else begin
      rdy_q <= rdy_d;
    end
  end

  assign reqReady    = rdy_q;
  assign busOut      = bus_q;
  assign pageWalk    = pw_q;
  assign dataFault   = flt_q;
  assign undefResult = und_q;
  assign noOp        = nop_q;
  assign regRdata    = rdata_q;

  ////////////////////////////////////////////////////////////////////
  a_second_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_q.valid && bus_q.addrOnly && !bus_q.isSecond |=> bus_q.valid && bus_q.isSecond)
    else $error("second packet missing");
  a_io_attr_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_q.valid && bus_q.addrOnly |-> bus_q.attr == ATTR_IO)
    else $error("io attributes wrong");
  a_memf_attr: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_q.valid && !bus_q.addrOnly |-> bus_q.attr == ATTR_MEMF)
    else $error("forced attributes wrong");
  a_no_io_walk: assert property (@(posedge core_clk) disable iff (!rst_n)
    reqValid && state_q == S_IDLE && isIo |=> !pageWalk)
    else $error("walk on io segment");
  a_key_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    reqValid && state_q == S_IDLE && isIo && !memForc && req.ixClass == IX_NORMAL
    |=> busOut.addr[31] == $past(keyBit))
    else $error("wrong key bit");
  a_fault_reserve: assert property (@(posedge core_clk) disable iff (!rst_n)
    reqValid && state_q == S_IDLE && isIo && req.ixClass == IX_RESERVE
    |=> dataFault && fault_q[FAULT_CAUSE_BIT] && !busOut.valid)
    else $error("reserve fault missing");
  a_cache_nop: assert property (@(posedge core_clk) disable iff (!rst_n)
    reqValid && state_q == S_IDLE && isIo && req.ixClass == IX_CACHEOP |=> noOp && !busOut.valid)
    else $error("cache op not dropped");
  a_second_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_q.valid && bus_q.isSecond |-> bus_q.addr[27:0] == $past(req.logAddr[27:0], 2))
    else $error("second packet address wrong");
  a_second_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_q.valid && bus_q.isSecond |-> bus_q.addr[31:28] == $past(segDesc_q[SD_HIGH_MSB:SD_HIGH_LSB], 2))
    else $error("second packet high bits wrong");
  a_second_only_after: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_q.valid && bus_q.isSecond |-> $past(bus_q.valid && bus_q.addrOnly && !bus_q.isSecond))
    else $error("second packet without first");
  a_io_select: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && !isIo |=> !busOut.valid)
    else $error("bus cycle on a plain segment");
  a_plain_walk: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && !isIo && !blockHit && req.ixClass == IX_NORMAL |=> pageWalk)
    else $error("plain segment not walked");
  a_hit_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && isIo && !memForc && blockHit && req.ixClass == IX_NORMAL
    |=> busOut.valid && busOut.addrOnly && !pageWalk)
    else $error("block hit not ignored");
  a_key_super: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && isIo && !memForc && req.ixClass == IX_NORMAL && !req.privState
    |=> busOut.addr[31] == $past(segDesc_q[SD_SKEY_POS]))
    else $error("supervisor key not sent");
  a_key_user: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && isIo && !memForc && req.ixClass == IX_NORMAL && req.privState
    |=> busOut.addr[31] == $past(segDesc_q[SD_UKEY_POS]))
    else $error("user key not sent");
  a_first_fields: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && isIo && !memForc && req.ixClass == IX_NORMAL
    |=> busOut.addr[28:0] == $past(segDesc_q[SD_BUS_UNIT_IDENTIFIER_MSB:0]) && busOut.addr[30:29] == 2'b00)
    else $error("first packet fields wrong");
  a_one_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    $onehot0({busOut.valid, pageWalk, dataFault, undefResult, noOp}))
    else $error("more than one answer");
  a_pair_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus_q.valid && bus_q.addrOnly && !bus_q.isSecond |-> ioCnt_q == $past(ioCnt_q) + 32'h00000001)
    else $error("pair count not advanced");
  a_forced_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && memForc && req.ixClass == IX_NORMAL
    |=> busOut.valid && !busOut.addrOnly
        && busOut.addr == {$past(segDesc_q[SD_HIGH_MSB:SD_HIGH_LSB]), $past(req.logAddr[27:0])})
    else $error("forced address wrong");
  a_forced_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && memForc && req.ixClass == IX_NORMAL |=> reqReady && state_q == S_IDLE)
    else $error("forced access started a pair");
  a_ext_undef: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && isIo && req.ixClass == IX_EXTCTL |=> undefResult && !busOut.valid)
    else $error("external control not flagged");
  a_nop_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && isIo && req.ixClass == IX_CACHEOP |=> !pageWalk && !dataFault && !undefResult)
    else $error("cache op had an effect");
  a_ready_second: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == S_SECOND |-> !reqReady)
    else $error("ready during second packet");
  a_fault_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(fault_q[FAULT_CAUSE_BIT]) && !$past(regWr && regAddr == ADDR_FAULT) |-> fault_q[FAULT_CAUSE_BIT])
    else $error("fault cause lost");
  a_fault_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && isIo && req.ixClass == IX_RESERVE && regWr && regAddr == ADDR_FAULT
    |=> fault_q[FAULT_CAUSE_BIT])
    else $error("fault cause lost to write");

  ////////////////////////////////////////////////////////////////////
  // register port checks
  a_desc_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    regWr && regAddr == ADDR_SEGDESC |=> segDesc_q == $past(regWdata))
    else $error("descriptor write lost");
  a_read_desc: assert property (@(posedge core_clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_SEGDESC |=> regRdata == $past(segDesc_q))
    else $error("descriptor read wrong");
  a_read_window: assert property (@(posedge core_clk) disable iff (!rst_n)
    !$past(regRd) |-> regRdata == 32'h00000000)
    else $error("read data outside its cycle");
  a_status_readonly: assert property (@(posedge core_clk) disable iff (!rst_n)
    regWr && regAddr == ADDR_STATUS && !(accept && isIo && !memForc && req.ixClass == IX_NORMAL)
    |=> ioCnt_q == $past(ioCnt_q))
    else $error("status count written");

  // main scenarios
  c_io_pair: cover property (@(posedge core_clk) bus_q.valid && bus_q.isSecond);
  c_forced: cover property (@(posedge core_clk) bus_q.valid && !bus_q.addrOnly);
  c_fault: cover property (@(posedge core_clk) dataFault);
  c_undef: cover property (@(posedge core_clk) undefResult);
  c_nop: cover property (@(posedge core_clk) noOp);

endmodule // iost_unit

/* File: test/iost_mem_model.sv */
`timescale 1ns/1ns
module iost_mem_model
  import iost_pkg::*;
(
  input  wire logic       core_clk,  // clock
  input  wire logic       rst_n,     // sync reset
  input  iost_bus_t       busOut,    // unit's bus output
  output logic            keyBit,    // key of last first packet
  output logic [7:0]      orderErrs  // packets seen out of pair order
);
  logic pendQ;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pendQ <= 1'h0;
      keyBit <= 1'h0;
      orderErrs <= 8'h00;
    end else if (busOut.valid && busOut.addrOnly) begin
      if (busOut.isSecond != pendQ) orderErrs <= orderErrs + 8'h01;
      if (!busOut.isSecond) keyBit <= busOut.addr[31];
      pendQ <= !busOut.isSecond;
    end else if (pendQ) begin
      // a lone first packet leaves the controller waiting forever
      orderErrs <= orderErrs + 8'h01;
      pendQ <= 1'h0;
    end
  end
endmodule // iost_mem_model

/* File: test/io_segment_translation_tb.sv */
`timescale 1ns/1ns
module io_segment_translation_tb import iost_pkg::*;;
  logic core_clk, rst_n, reqValid, blockHit, reqReady, pageWalk, dataFault, undefResult, noOp, regWr, regRd, keyBit;
  iost_req_t req;
  iost_bus_t busOut;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, desc, seed;
  logic [7:0] orderErrs;
  logic [41:0] obs;
  logic [41:0] q[$];
  int mismatches, n_compared, pairs;
  iost_unit DUT (.core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .blockHit(blockHit),
    .reqReady(reqReady), .pageWalk(pageWalk), .busOut(busOut), .dataFault(dataFault), .undefResult(undefResult),
    .noOp(noOp), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  iost_mem_model MC (.core_clk(core_clk), .rst_n(rst_n), .busOut(busOut), .keyBit(keyBit), .orderErrs(orderErrs));
  always #2 core_clk = ~core_clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [41:0] pkt(input logic ao, input logic sec, input logic [31:0] a, input logic [2:0] at);
    return {1'h1, ao, sec, a, at, 4'h0};
  endfunction
  task automatic chk(input string what, input logic [41:0] e, input logic [41:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a; regWdata <= d; regWr <= 1'h1;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a; regRd <= 1'h1;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1 chk("regRdata", {10'h000, e}, {10'h000, regRdata});
  endtask
  task automatic access(input iost_ixclass_t ix, input logic xl);
    iost_req_t r; logic k; logic [31:0] a; int w;
    seed = nxt(seed);
    r = '{logAddr: seed, kind: OP_STORE, ixClass: ix, privState: seed[7], dataXlateEn: xl};
    k = r.privState ? desc[29] : desc[30];
    a = {desc[3:0], seed[27:0]};
    w = 0;
    do begin @(posedge core_clk); #1 w++; end while (!reqReady && w < 20);
    if (!reqReady) begin mismatches++; tally_and_finish(); end
    @(posedge core_clk);
    req <= r; reqValid <= 1'h1; blockHit <= desc[31] & seed[9];
    if (!desc[31]) q.push_back(ix == IX_EXTCTL ? 42'h002 : 42'h008);
    else if (ix == IX_RESERVE) q.push_back(42'h004);
    else if (ix == IX_EXTCTL) q.push_back(42'h002);
    else if (ix == IX_CACHEOP) q.push_back(42'h001);
    else if (desc[28:20] == BUS_UNIT_IDENTIFIER_MEM_FORCED) q.push_back(pkt(1'h0, 1'h0, a, ATTR_MEMF));
    else begin
      q.push_back(pkt(1'h1, 1'h0, {k, 2'h0, desc[28:0]}, ATTR_IO));
      q.push_back(pkt(1'h1, 1'h1, a, ATTR_IO));
      pairs++;
    end
    @(posedge core_clk);
    reqValid <= 1'h0;
    if (desc[31] && ix == IX_NORMAL && desc[28:20] != BUS_UNIT_IDENTIFIER_MEM_FORCED) begin
      @(posedge core_clk);
      #1 chk("controller key", {41'h0, k}, {41'h0, keyBit});
    end
  endtask
  always @(negedge core_clk) if (rst_n) begin
    obs = {busOut, pageWalk, dataFault, undefResult, noOp};
    if (obs !== 42'h0) begin
      if (q.size() == 0) chk("unexpected output", 42'h0, obs);
      else chk("access result", q.pop_front(), obs);
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    core_clk = 0; rst_n = 0; reqValid = 0; req = '0; blockHit = 0;
    regAddr = 0; regWdata = 0; regWr = 0; regRd = 0; seed = 32'hA67D; pairs = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(ADDR_SEGDESC, SEGDESC_RST);
    rd(4'hC, 32'h0);
    wr(ADDR_STATUS, 32'hFFFF);
    rd(ADDR_STATUS, 32'h0);
    desc = 32'h0;
    access(IX_NORMAL, 1'h1);
    access(IX_EXTCTL, 1'h0);
    for (int i = 0; i < 3; i++) begin
      seed = nxt(seed);
      desc = {1'h1, seed[30:29], (i == 2) ? BUS_UNIT_IDENTIFIER_MEM_FORCED : seed[28:20], seed[19:0]};
      wr(ADDR_SEGDESC, desc);
      rd(ADDR_SEGDESC, desc);
      for (int j = 0; j < ((i == 2) ? 2 : 6); j++) access(iost_ixclass_t'(j % 4), 1'h1);
    end
    repeat (4) @(posedge core_clk);
    rd(ADDR_STATUS, pairs);
    rd(ADDR_FAULT, 32'h00000001 << FAULT_CAUSE_BIT);
    wr(ADDR_FAULT, 32'h00000000);
    rd(ADDR_FAULT, 32'h00000000);
    chk("controller order errors", 42'h0, {34'h0, orderErrs});
    chk("notes left", 42'h0, 42'(q.size()));
    tally_and_finish();
  end
endmodule // io_segment_translation_tb
